//--- shared/ccs_pkg.sv
// How it works
// RULE1 - high mode select: shared pin is external clock
// RULE2 - sixteen master clock ticks per channel
// RULE3 - host supplies external clock only when selected; ccs_host drives a pclk/2 toggle on the pin otherwise in software mode
// RULE4 - external clock duty no worse than 60/40
// RULE5 - software mode: low internal, high external clock
// RULE6 - low mode select: pins are channel selects
// RULE7 - hardware select high includes, low excludes
// RULE8 - hardware selects captured at start rising edge
// RULE9 - hardware mode always runs internal clock
// RULE10 - software mode: register selects, either clock
// RULE11 - software mode ignores hardware select pins
// RULE12 - standby input low enters power saving
// RULE13 - start edge holds, converts, latches selection
// RULE14 - write strobe rise loads select from data
// RULE15 - register bit 0 is channel 1, bit 3 channel 4
// RULE16 - ascending order, skip unselected, end after last
package ccs_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_CHAN_SEL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    // reset values
    localparam logic [3:0] CHAN_SEL_RST = 4'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    // status field positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LOWPWR_BIT = 1;
    localparam int ST_MODE_BIT = 2;
    localparam int ST_EXT_BIT = 3;
    localparam int ST_CHAN_LSB = 4;
    localparam int ST_SEQ_LSB = 8;
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam logic [3:0] CONV_LAST_TICK = 4'hF; // sixteen ticks, 0..15
    localparam logic [7:0] INT_DIV_DEFAULT = 8'h02;

    // conversion state, gray along idle -> convert
    typedef enum logic [0:0] {
        CCS_IDLE = 1'b0,
        CCS_CONV = 1'b1
    } ccs_state_t;

    // configuration and control pins from the host
    typedef struct packed {
        logic hw_sw_select;       // low hardware, high software control
        logic clk_in_chan1;       // external clock or hw_chan1_select
        logic clk_src_chan2;      // clock source or hw_chan2_select
        logic hw_chan3_select;
        logic hw_chan4_select;
        logic conversion_start;
        logic low_power_request_n;
        logic chip_select_n;
        logic read_n;
        logic write_n;
        logic [3:0] data_line;    // data_line_0 .. data_line_3
    } ccs_pins_t;

    // sequencer outputs
    typedef struct packed {
        logic busy;
        logic track_hold_hold;
        logic eoc_n;
        logic [1:0] channel;
        logic standby;
        logic ext_clock_used;
    } ccs_status_t;
endpackage : ccs_pkg

//--- src/ccs_top.sv
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
module ccs_top #(
    parameter logic [7:0] INT_DIV = ccs_pkg::INT_DIV_DEFAULT
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device pins
    input wire ccs_pkg::ccs_pins_t pins,
    // sequencer status
    output ccs_pkg::ccs_status_t status
);
    import ccs_pkg::*;

    ccs_pins_t sync1_ff;
    ccs_pins_t sync2_ff;
    ccs_pins_t prev_ff;
    ccs_state_t state_ff;
    logic [1:0] chan_ff;
    logic [3:0] seq_ff;
    logic [3:0] tick_cnt_ff;
    logic [7:0] div_ff;
    logic ext_src_ff;
    logic eoc_ff;
    logic [3:0] chan_sel_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;

    logic conv_rise;
    logic pin_write;
    logic ext_rise;
    logic int_tick;
    logic tick;
    logic sw_mode;
    logic awake;
    logic start_go;
    logic last_tick;
    logic [3:0] hw_sel;
    logic [3:0] nxt_seq;
    logic nxt_ext;
    logic [2:0] first_hit;
    logic [2:0] next_hit;
    logic apb_access;
    logic addr_ok;

    // lowest selected channel at or above start; bit 2 flags a hit
    function automatic logic [2:0] first_from(input logic [3:0] sel, input logic [2:0] start);
        logic [2:0] res;
        res = 3'b000;
        for (int i = 3; i >= 0; i--) begin
            if (sel[i] && (3'(i) >= start)) begin
                res = {1'b1, 2'(i)};
            end
        end
        return res;
    endfunction : first_from

    // two flops on every pin; only the second stage is looked at
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else if (ce) begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
        end
    end

    // previous synced level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= '0;
        end else if (ce) begin
            prev_ff <= sync2_ff;
        end
    end

    assign sw_mode = sync2_ff.hw_sw_select;
    assign awake = sync2_ff.low_power_request_n; // RULE12
    assign conv_rise = ce && sync2_ff.conversion_start && !prev_ff.conversion_start;
    // external clock is sampled, so it must run below half of pclk
    assign ext_rise = ce && sync2_ff.clk_in_chan1 && !prev_ff.clk_in_chan1; // RULE1
    assign pin_write = ce && sync2_ff.write_n && !prev_ff.write_n
        && !sync2_ff.chip_select_n && sync2_ff.read_n; // RULE14

    // shared pins act as channel selects only in hardware mode
    assign hw_sel = {sync2_ff.hw_chan4_select, sync2_ff.hw_chan3_select,
        sync2_ff.clk_src_chan2, sync2_ff.clk_in_chan1}; // RULE6 RULE7 RULE15
    // software mode reads the register and ignores the select pins
    assign nxt_seq = sw_mode ? chan_sel_ff : hw_sel; // RULE10 RULE11 RULE8
    // hardware mode forces the internal clock
    assign nxt_ext = sw_mode && sync2_ff.clk_src_chan2; // RULE5 RULE9

    assign first_hit = first_from(nxt_seq, 3'b000); // RULE16
    assign next_hit = first_from(seq_ff, 3'({1'b0, chan_ff} + 3'b001)); // RULE16
    // a start while busy or in standby is dropped
    assign start_go = conv_rise && (state_ff == CCS_IDLE) && awake; // RULE13
    assign tick = ce && (ext_src_ff ? ext_rise : int_tick);
    assign last_tick = tick && (tick_cnt_ff == CONV_LAST_TICK); // RULE2

    // internal master clock divider, kept quiet outside conversions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 8'h00;
        end else if (ce) begin
            if (state_ff == CCS_IDLE || div_ff == INT_DIV - 8'h01) begin
                div_ff <= 8'h00;
            end else begin
                div_ff <= div_ff + 8'h01;
            end
        end
    end
    assign int_tick = (state_ff == CCS_CONV) && (div_ff == INT_DIV - 8'h01);

    // sequencer state, channel and latched selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= CCS_IDLE;
            chan_ff <= 2'b00;
            seq_ff <= 4'h0;
            ext_src_ff <= 1'b0;
        end else if (ce) begin
            if (!awake) begin
                state_ff <= CCS_IDLE; // RULE12
            end else if (start_go) begin
                seq_ff <= nxt_seq; // RULE8 RULE13
                ext_src_ff <= nxt_ext; // RULE5 RULE9
                chan_ff <= first_hit[1:0];
                state_ff <= first_hit[2] ? CCS_CONV : CCS_IDLE;
            end else if (state_ff == CCS_CONV && last_tick) begin
                chan_ff <= next_hit[1:0]; // RULE16
                state_ff <= next_hit[2] ? CCS_CONV : CCS_IDLE; // RULE16
            end
        end
    end

    // tick counter within one channel conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= 4'h0;
        end else if (ce) begin
            if (state_ff == CCS_IDLE || !awake) begin
                tick_cnt_ff <= 4'h0;
            end else if (tick) begin
                tick_cnt_ff <= tick_cnt_ff + 4'h1; // RULE2 wraps after sixteen
            end
        end
    end

    // end of conversion pulse, one pclk per channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eoc_ff <= 1'b0;
        end else if (ce) begin
            eoc_ff <= (state_ff == CCS_CONV) && last_tick && awake; // RULE2
        end
    end

    // channel select register: pin strobe wins over a same-cycle apb write
    assign apb_access = ce && psel && penable;
    assign addr_ok = (paddr == ADDR_CHAN_SEL) || (paddr == ADDR_STATUS);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_sel_ff <= CHAN_SEL_RST;
        end else if (pin_write) begin
            chan_sel_ff <= sync2_ff.data_line; // RULE14 RULE15
        end else if (apb_access && pwrite && paddr == ADDR_CHAN_SEL) begin
            chan_sel_ff <= pwdata[3:0]; // RULE15
        end
    end

    // apb read data and error, registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= RDATA_ZERO;
            pslverr_ff <= 1'b0;
        end else if (ce) begin
            prdata_ff <= RDATA_ZERO;
            pslverr_ff <= 1'b0;
            if (psel && !penable) begin
                pslverr_ff <= !addr_ok;
                if (!pwrite && paddr == ADDR_CHAN_SEL) begin
                    prdata_ff[3:0] <= chan_sel_ff;
                end else if (!pwrite && paddr == ADDR_STATUS) begin
                    prdata_ff[ST_BUSY_BIT] <= (state_ff == CCS_CONV);
                    prdata_ff[ST_LOWPWR_BIT] <= !awake;
                    prdata_ff[ST_MODE_BIT] <= sw_mode;
                    prdata_ff[ST_EXT_BIT] <= ext_src_ff;
                    prdata_ff[ST_CHAN_LSB +: 2] <= chan_ff;
                    prdata_ff[ST_SEQ_LSB +: 4] <= seq_ff;
                end
            end
        end
    end
    // setup cycle prepares data, so an access answers at once whenever ce is high
    assign pready = ce;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff && penable;

    // sequencer outputs
    assign status.busy = (state_ff == CCS_CONV);
    assign status.track_hold_hold = (state_ff == CCS_CONV); // RULE13
    assign status.eoc_n = !eoc_ff;
    assign status.channel = chan_ff;
    assign status.standby = !awake; // RULE12
    assign status.ext_clock_used = ext_src_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    // a start latches the right selection and clock source
    hw_select_a: assert property (start_go && !sw_mode |=> seq_ff == $past(hw_sel)) // RULE8
        else $error("hardware selection not latched at start");
    sw_select_a: assert property (start_go && sw_mode |=> seq_ff == $past(chan_sel_ff)) // RULE11
        else $error("register selection not latched at start");
    hw_int_clock_a: assert property (start_go && !sw_mode |=> !ext_src_ff) // RULE9
        else $error("hardware mode used external clock");
    sw_clock_src_a: assert property (start_go && sw_mode
        |=> ext_src_ff == $past(sync2_ff.clk_src_chan2)) // RULE5
        else $error("software clock source wrong");
    // each end of conversion follows the sixteenth tick
    sixteen_ticks_a: assert property (eoc_ff |-> $past(tick) && $past(tick_cnt_ff) == 4'hF) // RULE2
        else $error("conversion did not take sixteen ticks");
    ascending_a: assert property (status.busy && $past(status.busy) && chan_ff != $past(chan_ff)
        |-> chan_ff > $past(chan_ff)) // RULE16
        else $error("channel order not ascending");
    selected_only_a: assert property (status.busy |-> seq_ff[chan_ff]) // RULE16
        else $error("unselected channel converted");
    standby_stop_a: assert property (!awake |=> !status.busy) // RULE12
        else $error("conversion ran in standby");
    hold_on_start_a: assert property (start_go && first_hit[2] |=> status.track_hold_hold) // RULE13
        else $error("start did not enter hold");
    pin_write_a: assert property (pin_write |=> chan_sel_ff == $past(sync2_ff.data_line)) // RULE14
        else $error("write strobe did not load select");
    ext_pin_clock_a: assert property (status.busy && ext_src_ff && tick |-> ext_rise) // RULE1
        else $error("external tick without clock edge");

    full_seq_c: cover property (start_go && nxt_seq == 4'hF);
    ext_conv_c: cover property (eoc_ff && ext_src_ff);
    skip_chan_c: cover property (start_go && nxt_seq == 4'h5);
    lowpwr_abort_c: cover property (status.busy && !awake);
endmodule : ccs_top

//--- sim/ccs_host.sv
`timescale 1ns/10ps
module ccs_host (
    // clock
    input wire logic pclk,
    // requests from the bench
    input wire logic ext_clk_run,
    input wire ccs_pkg::ccs_pins_t req,
    // pins seen by the device
    output ccs_pkg::ccs_pins_t pins
);
    import ccs_pkg::*;
    logic [2:0] div_ff = 3'h0;
    logic clk_ff = 1'b0;

    // conversion clock, 8 pclk period, even duty; toggles every 4 so each level lasts 4 pclk
    always_ff @(posedge pclk) begin
        div_ff <= div_ff + 3'h1;
        if (div_ff[1:0] == 2'h3) begin
            clk_ff <= ~clk_ff;
        end
    end

    // in software mode the shared pin carries the clock when ext_clk_run is set, otherwise a pclk/2 toggle
    always_comb begin
        pins = req;
        if (req.hw_sw_select) begin
            pins.clk_in_chan1 = ext_clk_run ? clk_ff : div_ff[0];
        end
    end
endmodule : ccs_host

//--- sim/ccs_top_tb.sv
`timescale 1ns/10ps
module ccs_top_tb;
    import ccs_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, ext_run = 1'b0;
    ccs_pins_t drv = '{low_power_request_n: 1'b1, chip_select_n: 1'b1, read_n: 1'b1,
        write_n: 1'b1, default: 1'b0};
    ccs_pins_t pins;
    ccs_status_t status;
    int error_cnt = 0, check_count = 0, i;

    // 20 MHz clock
    always #25 pclk = ~pclk;

    ccs_host host (.pclk(pclk), .ext_clk_run(ext_run), .req(drv), .pins(pins));
    ccs_top #(.INT_DIV(8'h03)) uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .status(status));

    task final_report;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen at a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) begin
            error_cnt++;
            final_report;
        end
    endtask : apb

    // pin write cycle, strobe held low 3 pclk and high 4 pclk so the synchronisers see it
    task pin_wr(input logic [3:0] d, input logic cs_n);
        @(posedge pclk);
        drv.data_line <= d;
        drv.chip_select_n <= cs_n;
        drv.write_n <= 1'b0;
        repeat (3) @(posedge pclk);
        drv.write_n <= 1'b1;
        repeat (4) @(posedge pclk);
        drv.chip_select_n <= 1'b1;
        apb(1'b0, ADDR_CHAN_SEL, 32'h0);
    endtask : pin_wr

    // one conversion sequence; channel order worked out from the mask, eoc spacing from the clock source
    task run_conv(input logic sw, input logic ext, input logic [3:0] m);
        logic [1:0] seen[$];
        int n, ne, last, k;
        logic was;
        seen.delete();
        ne = 0;
        last = 0;
        was = 1'b0;
        k = 0;
        if (sw) apb(1'b1, ADDR_CHAN_SEL, {28'h0, m});
        @(posedge pclk);
        drv.hw_sw_select <= sw;
        drv.clk_src_chan2 <= sw ? ext : m[1];
        drv.clk_in_chan1 <= m[0];
        drv.hw_chan3_select <= sw ? 1'($urandom) : m[2];
        drv.hw_chan4_select <= sw ? 1'($urandom) : m[3];
        ext_run <= ext;
        repeat (4) @(posedge pclk);
        drv.conversion_start <= 1'b1;
        for (n = 0; n < 3000; n++) begin
            @(posedge pclk);
            #1;
            if (status.busy === 1'b1) begin
                // selects move after the start edge; the latched set must not follow
                if (!sw) drv[12:9] <= 4'($urandom);
                was = 1'b1;
                if (seen.size() == 0 || seen[$] !== status.channel) seen.push_back(status.channel);
            end
            if (status.track_hold_hold !== status.busy) chk("hold", 32'(status.busy), 32'h1);
            if (status.eoc_n === 1'b0) begin
                if (ne > 0) chk("eoc gap", ext ? 32'd128 : 32'd48, 32'(n - last));
                ne++;
                last = n;
            end
            if ((was && status.busy === 1'b0) || (m == 4'h0 && n == 60)) break;
        end
        drv.conversion_start <= 1'b0;
        if (n == 3000) begin
            error_cnt++;
            final_report;
        end
        chk("eoc count", 32'($countones(m)), 32'(ne));
        for (int c = 0; c < 4; c++) begin
            if (m[c]) chk("channel", 32'(c), 32'(seen[k++]));
        end
        chk("seq len", 32'($countones(m)), 32'(seen.size()));
    endtask : run_conv

    initial begin
        logic [3:0] cfg[5] = '{4'hF, 4'h0, 4'h8, 4'h1, 4'h6};
        logic [1:0] mode[5] = '{2'b00, 2'b00, 2'b10, 2'b11, 2'b11};
        i = $urandom(3);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CHAN_SEL, 32'h0);
        chk("chan_sel reset", 32'h0000_0000, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        apb(1'b1, ADDR_CHAN_SEL, 32'hFFFF_FFF5);
        apb(1'b0, ADDR_CHAN_SEL, 32'h0);
        chk("chan_sel rw", 32'h0000_0005, rd);
        pin_wr(4'hA, 1'b0);
        chk("pin write", 32'h0000_000A, rd);
        pin_wr(4'h3, 1'b1);
        chk("pin write cs high", 32'h0000_000A, rd);
        for (i = 0; i < 5; i++) run_conv(mode[i][1], mode[i][0], cfg[i]);
        for (i = 0; i < 6; i++) run_conv(1'($urandom), 1'($urandom), 4'($urandom));
        // standby in mid sequence aborts, and a start while in standby is ignored
        run_conv(1'b0, 1'b0, 4'h0);
        @(posedge pclk);
        drv[12:9] <= 4'hF;
        drv.conversion_start <= 1'b1;
        repeat (12) @(posedge pclk);
        drv.low_power_request_n <= 1'b0;
        drv.conversion_start <= 1'b0;
        repeat (6) @(posedge pclk);
        drv.conversion_start <= 1'b1;
        repeat (8) @(posedge pclk);
        #1;
        chk("standby busy", 32'h0, 32'(status.busy));
        chk("standby flag", 32'h1, 32'(status.standby));
        final_report;
    end
endmodule : ccs_top_tb
